// ==== tb/aca_chk.sv ====
// Concurrent checks on the command link between the host and device ends.
// Assumes it sees the link signals with the shared clock and reset.
`include "aca_params.svh"
`default_nettype none

module aca_chk
    import aca_pkg::*;
#(
    parameter logic [31:0] OWN_SERIAL = 32'h0000_0000,
    parameter logic [15:0] CUSTOMER_CODE = 16'h0000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire aca_pkg::aca_byte_t cmd_byte,
    input wire logic rsp_valid,
    input wire aca_pkg::aca_byte_t rsp_byte
);
    timeunit 1ns;
    timeprecision 1ns;

    aca_byte_t b1_ff, b2_ff, b3_ff, mode_ff;
    logic [2:0] v_ff;
    logic hdr_ok;
    logic rd_frame;
    logic wr_frame;
    logic ro_hit;
    aca_byte_t ro_exp;

    // --------------------------------------------------------------
    // Frame tracking
    // --------------------------------------------------------------
    // A frame ends on this byte when three consecutive bytes precede it and the first two of them are FF 02.
    assign hdr_ok = cmd_valid && (v_ff == 3'h7) && (b3_ff == `ACA_HDR_BYTE)
                    && (b2_ff == `ACA_SIZE_BYTE);
    assign rd_frame = hdr_ok && (b1_ff == `ACA_ESC_BYTE);
    assign wr_frame = hdr_ok && (b1_ff != `ACA_ESC_BYTE);
    // Expected contents of the read-only places, chosen by address byte.
    assign ro_hit = cmd_byte inside {[8'h34:8'h37], 8'h39, 8'h3A};
    assign ro_exp = (cmd_byte == `ACA_OFS_SERIAL3) ? OWN_SERIAL[31:24] :
                    (cmd_byte == `ACA_OFS_SERIAL2) ? OWN_SERIAL[23:16] :
                    (cmd_byte == `ACA_OFS_SERIAL1) ? OWN_SERIAL[15:8] :
                    (cmd_byte == `ACA_OFS_SERIAL0) ? OWN_SERIAL[7:0] :
                    (cmd_byte == `ACA_OFS_CUST_HIGH) ? CUSTOMER_CODE[15:8] :
                    CUSTOMER_CODE[7:0];

    // Byte history and a shadow of the volatile link mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            v_ff <= 3'h0;
            mode_ff <= `ACA_RST_LINK_MODE;
        end else begin
            v_ff <= {v_ff[1:0], cmd_valid};
            if (cmd_valid) begin
                b1_ff <= cmd_byte;
                b2_ff <= b1_ff;
                b3_ff <= b2_ff;
            end
            if (wr_frame && b1_ff == `ACA_OFS_LINK_MODE_V && cmd_byte inside
                {`ACA_MODE_LEGACY, `ACA_MODE_NORMAL, `ACA_MODE_NETWORK}) begin
                mode_ff <= cmd_byte;
            end
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_read_ack: assert property (rd_frame |=> rsp_valid && rsp_byte == `ACA_ACK_BYTE)
        else $error("Read not answered with the acknowledge byte.");
    chk_read_addr: assert property (rd_frame |=> ##1 rsp_valid && rsp_byte == $past(cmd_byte, 2))
        else $error("Read answer does not echo the address.");
    chk_answer_len: assert property ($rose(rsp_valid) |-> rsp_valid [*3] ##1 !rsp_valid)
        else $error("Answer is not three bytes long.");
    chk_answer_cause: assert property ($rose(rsp_valid) |-> $past(rd_frame))
        else $error("Answer without a read command.");
    chk_write_silent: assert property (wr_frame |=> !rsp_valid [*3])
        else $error("Write command was answered.");
    chk_ro_value: assert property (rd_frame && ro_hit |=> ##2 rsp_byte == $past(ro_exp, 3))
        else $error("Serial or customer code byte is wrong.");
    chk_mode_value: assert property (rd_frame && cmd_byte == `ACA_OFS_LINK_MODE_V
        |=> ##2 rsp_byte == $past(mode_ff, 3))
        else $error("Link mode read does not match the last legal write.");
    chk_nv_upper: assert property (rd_frame && cmd_byte == `ACA_OFS_CAPTURE_NV
        |=> ##2 rsp_byte[7:4] == 4'h0)
        else $error("Stored capture setting has a nonzero upper nibble.");
endmodule

`default_nettype wire

// ==== tb/aca_tb.sv ====
// Self-checking bench joining the host and device ends over the link.
// Assumes the design sources and link interface are compiled first.
`include "aca_params.svh"
`default_nettype none

module aca_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] SER = 32'h9A3C_5E71; // Arbitrary serial for this bench.
    localparam logic [15:0] CUS = 16'h4B2D; // Arbitrary customer code for this bench.
    logic clk, sys_rst, req_valid, req_write, busy, done, rd_ok;
    logic [7:0] req_addr, req_wdata, rd_data, link_mode;
    logic rx_pkt_valid, dest_is_ext_user, dest_load;
    logic [3:0] rx_pkt_type;
    logic [31:0] rx_src_addr, user_destination, serial_destination, tx_origin_addr;
    logic [15:0] rx_cust_code;
    logic [31:0] exp_ser, exp_usr;
    int mismatches, n_checks;

    // --------------------------------------------------------------
    // Design and checker
    // --------------------------------------------------------------
    aca_if i_aca_if ();
    aca_host i_aca_host (.clk, .sys_rst, .link(i_aca_if), .req_valid, .req_write,
        .req_addr, .req_wdata, .busy, .done, .rd_ok, .rd_data);
    aca_dev #(.OWN_SERIAL(SER), .CUSTOMER_CODE(CUS)) i_aca_dev (.clk, .sys_rst,
        .link(i_aca_if), .rx_pkt_valid, .rx_pkt_type, .rx_src_addr, .rx_cust_code,
        .link_mode, .user_destination, .serial_destination, .dest_is_ext_user,
        .dest_load, .tx_origin_addr);
    aca_chk #(.OWN_SERIAL(SER), .CUSTOMER_CODE(CUS)) i_aca_chk (.clk, .sys_rst,
        .cmd_valid(i_aca_if.cmd_valid), .cmd_byte(i_aca_if.cmd_byte),
        .rsp_valid(i_aca_if.rsp_valid), .rsp_byte(i_aca_if.rsp_byte));

    // The clock runs at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Issues one host request and waits a bounded time for its done pulse.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = addr;
        req_wdata = wd;
        @(negedge clk);
        req_valid = 1'b0;
        cmp({31'h0, busy}, 32'h1);
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmp(n, wr ? 32'd3 : 32'd7);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        xfer(1'b0, addr, 8'h00);
        cmp({31'h0, rd_ok}, 32'h1);
        cmp({24'h0, rd_data}, {24'h0, exp});
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset_values();
        cmp(tx_origin_addr, SER);
        cmp({24'h0, link_mode}, {24'h0, `ACA_MODE_NORMAL});
        cmp(serial_destination | user_destination, 32'h0);
        rd_chk(`ACA_OFS_LINK_MODE_V, `ACA_MODE_NORMAL);
        rd_chk(`ACA_OFS_CAPTURE_V, 8'h00);
        rd_chk(`ACA_OFS_SERIAL3, SER[31:24]);
        rd_chk(`ACA_OFS_SERIAL2, SER[23:16]);
        rd_chk(`ACA_OFS_SERIAL1, SER[15:8]);
        rd_chk(`ACA_OFS_SERIAL0, SER[7:0]);
        rd_chk(`ACA_OFS_CUST_HIGH, CUS[15:8]);
        rd_chk(`ACA_OFS_CUST_LOW, CUS[7:0]);
    endtask

    // Writes to read-only places are dropped; an unmapped place reads zero.
    task automatic t_read_only();
        xfer(1'b1, `ACA_OFS_SERIAL0, 8'h00);
        rd_chk(`ACA_OFS_SERIAL0, SER[7:0]);
        xfer(1'b1, `ACA_OFS_CUST_LOW, ~CUS[7:0]);
        rd_chk(`ACA_OFS_CUST_LOW, CUS[7:0]);
        rd_chk(8'h50, 8'h00);
    endtask

    // Every legal mode is taken; an illegal value leaves the mode alone.
    task automatic t_link_mode();
        logic [7:0] vals [4];
        logic [7:0] exp;
        vals = '{8'h00, 8'h03, 8'h01, 8'h02};
        exp = `ACA_MODE_NORMAL;
        foreach (vals[i]) begin
            xfer(1'b1, `ACA_OFS_LINK_MODE_V, vals[i]);
            if (vals[i] != 8'h01) exp = vals[i];
            rd_chk(`ACA_OFS_LINK_MODE_V, exp);
            cmp({24'h0, link_mode}, {24'h0, exp});
        end
        xfer(1'b1, `ACA_OFS_LINK_MODE_NV, `ACA_MODE_NETWORK);
        rd_chk(`ACA_OFS_LINK_MODE_NV, `ACA_MODE_NETWORK);
        xfer(1'b1, `ACA_OFS_CAPTURE_NV, 8'hA7);
        rd_chk(`ACA_OFS_CAPTURE_NV, 8'h07);
    endtask

    // Sets a capture setting, offers one packet and checks what was filled.
    task automatic cap_case(input logic [3:0] cfg, input logic [3:0] typ,
                            input logic [15:0] cust, input logic hit);
        logic s1;
        logic s2;
        logic [31:0] src;
        src = {16'hC0DE, 4'h0, cfg, 4'h0, typ};
        xfer(1'b1, `ACA_OFS_CAPTURE_V, {4'h0, cfg});
        @(negedge clk);
        rx_pkt_valid = 1'b1;
        rx_pkt_type = typ;
        rx_src_addr = src;
        rx_cust_code = cust;
        @(negedge clk);
        rx_pkt_valid = 1'b0;
        s1 = dest_load;
        @(negedge clk);
        s2 = dest_load;
        cmp({31'h0, s1 | s2}, {31'h0, hit});
        cmp({31'h0, s1 & s2}, 32'h0);
        if (hit && typ == `ACA_TYPE_SERIAL) exp_ser = src;
        if (hit && typ != `ACA_TYPE_SERIAL) exp_usr = src;
        cmp(serial_destination, exp_ser);
        cmp(user_destination, exp_usr);
        if (hit && typ != `ACA_TYPE_SERIAL)
            cmp({31'h0, dest_is_ext_user}, {31'h0, typ == 4'h7});
        rd_chk(`ACA_OFS_CAPTURE_V, hit ? {typ, cfg} : {4'h0, cfg});
    endtask

    task automatic t_capture();
        cap_case(4'h0, 4'h4, CUS, 1'b0);
        cap_case(4'h4, 4'h4, CUS, 1'b1);
        cap_case(4'h4, 4'h6, CUS, 1'b0);
        cap_case(4'h6, 4'h6, CUS, 1'b1);
        cap_case(4'h6, 4'h7, CUS, 1'b0);
        cap_case(4'h7, 4'h7, CUS, 1'b1);
        cap_case(4'hF, 4'h6, CUS, 1'b1);
        cap_case(4'hF, 4'h4, CUS, 1'b1);
        cap_case(4'hF, 4'h7, ~CUS, 1'b0);
        cap_case(4'hF, 4'h4, ~CUS, 1'b1);
    endtask

    // --------------------------------------------------------------
    // Run control
    // --------------------------------------------------------------
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        rx_pkt_valid = 1'b0;
        rx_pkt_type = 4'h0;
        rx_src_addr = 32'h0;
        rx_cust_code = 16'h0;
        mismatches = 0;
        n_checks = 0;
        exp_ser = 32'h0;
        exp_usr = 32'h0;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_reset_values();
        t_read_only();
        t_link_mode();
        t_capture();
        // A second reset in mid-run brings back every reset value.
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        exp_ser = 32'h0;
        exp_usr = 32'h0;
        t_reset_values();
        wrap_up();
    end
endmodule

`default_nettype wire

// ==== verilog/aca_dev.sv ====
// Device end: addressing configuration registers behind the command link.
// Assumes a host on the same clock and a radio engine that reports packets.
`include "aca_params.svh"
`default_nettype none

// Operation
// - Host frames: FF 02 FE addr, FF 02 addr value
// - Read answered with 06, address, value
// - Link mode values 00, 02, 03
// - Capture source address into destination registers
// - Capture setting selects which packet types fill
// - Stored capture copy keeps upper nibble zero
// - Received type written to upper indicator nibble
// - Host writes indicator nibble as zero; the device loads it from the upper bits of the value byte
// - Indicator codes 4, 6, 7
// - Serial number read-only at 34..37
// - Own serial sent as origin address
// - Customer code read-only at 39..3A
// - User modes match on customer code
// - Host replies in the received addressing mode
module aca_dev
    import aca_pkg::*;
#(
    parameter logic [31:0] OWN_SERIAL = `ACA_RST_SERIAL,
    parameter logic [15:0] CUSTOMER_CODE = `ACA_RST_CUSTOMER
) (
    input wire logic clk,
    input wire logic sys_rst,
    aca_if.dev link,
    input wire logic rx_pkt_valid,
    input wire aca_pkg::aca_nibble_t rx_pkt_type,
    input wire logic [31:0] rx_src_addr,
    input wire logic [15:0] rx_cust_code,
    output logic [7:0] link_mode,
    output logic [31:0] user_destination,
    output logic [31:0] serial_destination,
    output logic dest_is_ext_user,
    output logic dest_load,
    output logic [31:0] tx_origin_addr
);
    import aca_pkg::*;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------

    // Returns the value of the register at the given offset.
    function automatic aca_byte_t reg_value(input aca_byte_t addr, input aca_byte_t mode_nv,
                                            input aca_byte_t mode_v, input aca_nibble_t cap_nv,
                                            input aca_byte_t cap_v);
        aca_byte_t val;
        val = 8'h00;
        unique case (addr)
            `ACA_OFS_LINK_MODE_NV: val = mode_nv;
            `ACA_OFS_CAPTURE_NV: val = {4'h0, cap_nv};
            `ACA_OFS_SERIAL3: val = OWN_SERIAL[31:24];
            `ACA_OFS_SERIAL2: val = OWN_SERIAL[23:16];
            `ACA_OFS_SERIAL1: val = OWN_SERIAL[15:8];
            `ACA_OFS_SERIAL0: val = OWN_SERIAL[7:0];
            `ACA_OFS_CUST_HIGH: val = CUSTOMER_CODE[15:8];
            `ACA_OFS_CUST_LOW: val = CUSTOMER_CODE[7:0];
            `ACA_OFS_LINK_MODE_V: val = mode_v;
            `ACA_OFS_CAPTURE_V: val = cap_v;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // True for the three documented link mode values.
    function automatic logic mode_legal(input aca_byte_t v);
        return (v == `ACA_MODE_LEGACY) || (v == `ACA_MODE_NORMAL) ||
               (v == `ACA_MODE_NETWORK);
    endfunction

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    aca_dev_state_t state_ff;
    aca_dev_state_t nxt_state;
    aca_byte_t addr_ff;
    aca_byte_t mode_nv_ff;
    aca_byte_t mode_v_ff;
    aca_nibble_t cap_nv_ff;
    aca_nibble_t cap_cfg_ff;
    aca_nibble_t cap_type_ff;
    logic rsp_valid_ff;
    aca_byte_t rsp_byte_ff;
    logic [31:0] user_dest_ff;
    logic [31:0] serial_dest_ff;
    logic ext_ff;
    logic load_ff;
    logic [31:0] origin_ff;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire logic take = link.cmd_valid;
    wire aca_byte_t byte_in = link.cmd_byte;
    wire aca_byte_t cap_v_value = {cap_type_ff, cap_cfg_ff};
    wire aca_byte_t rd_value = reg_value(addr_ff, mode_nv_ff, mode_v_ff, cap_nv_ff,
                                         cap_v_value);
    // value byte completes a write frame.
    wire logic wr_strobe = take && (state_ff == DEV_WVAL);
    wire logic wr_mode_nv = wr_strobe && (addr_ff == `ACA_OFS_LINK_MODE_NV);
    wire logic wr_mode_v = wr_strobe && (addr_ff == `ACA_OFS_LINK_MODE_V);
    wire logic wr_cap_nv = wr_strobe && (addr_ff == `ACA_OFS_CAPTURE_NV);
    wire logic wr_cap_v = wr_strobe && (addr_ff == `ACA_OFS_CAPTURE_V);
    wire logic byte_mode_ok = mode_legal(byte_in);

    // ------------------------------------------------------------
    // Received packet qualification
    // ------------------------------------------------------------
    wire logic is_serial = rx_pkt_type == `ACA_TYPE_SERIAL;
    wire logic is_user = rx_pkt_type == `ACA_TYPE_USER;
    wire logic is_ext = rx_pkt_type == `ACA_TYPE_EXT_USER;
    wire logic cust_ok = rx_cust_code == CUSTOMER_CODE;
    wire logic pkt_ok = rx_pkt_valid && (is_serial || ((is_user || is_ext) && cust_ok));
    wire logic cap_hit = pkt_ok && (cap_cfg_ff != `ACA_CAP_OFF) &&
                         ((cap_cfg_ff == `ACA_CAP_ANY) || (cap_cfg_ff == rx_pkt_type));

    // ------------------------------------------------------------
    // Frame parser and answer sequencer
    // ------------------------------------------------------------

    // Next state; the answer runs three cycles and ignores input bytes.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DEV_HDR: if (take && byte_in == `ACA_HDR_BYTE) nxt_state = DEV_SIZE;
            DEV_SIZE: if (take) nxt_state = (byte_in == `ACA_SIZE_BYTE) ? DEV_FIRST : DEV_HDR;
            DEV_FIRST: if (take) nxt_state = (byte_in == `ACA_ESC_BYTE) ? DEV_RADDR : DEV_WVAL;
            DEV_RADDR: if (take) nxt_state = DEV_ACK;
            DEV_WVAL: if (take) nxt_state = DEV_HDR;
            DEV_ACK: nxt_state = DEV_RSPA;
            DEV_RSPA: nxt_state = DEV_RVAL;
            DEV_RVAL: nxt_state = DEV_HDR;
        endcase
    end

    // Parser state and captured address.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= DEV_HDR;
            addr_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (take && (state_ff == DEV_RADDR || (state_ff == DEV_FIRST &&
                         byte_in != `ACA_ESC_BYTE))) begin
                addr_ff <= byte_in;
            end
        end
    end

    // answer bytes: acknowledge, address, then current value.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_byte_ff <= 8'h00;
        end else begin
            rsp_valid_ff <= (nxt_state == DEV_ACK) || (nxt_state == DEV_RSPA) ||
                            (nxt_state == DEV_RVAL);
            if (nxt_state == DEV_ACK) begin
                rsp_byte_ff <= `ACA_ACK_BYTE;
            end else if (nxt_state == DEV_RSPA) begin
                rsp_byte_ff <= addr_ff;
            end else if (nxt_state == DEV_RVAL) begin
                rsp_byte_ff <= rd_value;
            end else begin
                rsp_byte_ff <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // link mode copies accept only legal values.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_nv_ff <= `ACA_RST_LINK_MODE;
            mode_v_ff <= `ACA_RST_LINK_MODE;
        end else begin
            if (wr_mode_nv && byte_mode_ok) mode_nv_ff <= byte_in;
            if (wr_mode_v && byte_mode_ok) mode_v_ff <= byte_in;
        end
    end

    // stored copy keeps only the low nibble; type set wins over a host write.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap_nv_ff <= `ACA_RST_CAPTURE;
            cap_cfg_ff <= `ACA_RST_CAPTURE;
            cap_type_ff <= 4'h0;
        end else begin
            if (wr_cap_nv) cap_nv_ff <= byte_in[3:0];
            if (wr_cap_v) cap_cfg_ff <= byte_in[3:0];
            // host write loads the indicator nibble from the upper bits of the value byte.
            // indicator takes the packet type code.
            if (cap_hit) begin
                cap_type_ff <= rx_pkt_type;
            end else if (wr_cap_v) begin
                cap_type_ff <= byte_in[7:4];
            end
        end
    end

    // ------------------------------------------------------------
    // Reply address capture
    // ------------------------------------------------------------

    // source address fills the matching destination register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            user_dest_ff <= 32'h0000_0000;
            serial_dest_ff <= 32'h0000_0000;
            ext_ff <= 1'b0;
            load_ff <= 1'b0;
        end else begin
            load_ff <= cap_hit;
            if (cap_hit && is_serial) serial_dest_ff <= rx_src_addr;
            if (cap_hit && !is_serial) begin
                user_dest_ff <= rx_src_addr;
                ext_ff <= is_ext;
            end
        end
    end

    // own serial number is the origin address.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            origin_ff <= OWN_SERIAL;
        end else begin
            origin_ff <= OWN_SERIAL;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.rsp_valid = rsp_valid_ff;
    assign link.rsp_byte = rsp_byte_ff;
    assign link_mode = mode_v_ff;
    assign user_destination = user_dest_ff;
    assign serial_destination = serial_dest_ff;
    assign dest_is_ext_user = ext_ff;
    assign dest_load = load_ff;
    assign tx_origin_addr = origin_ff;
endmodule

`default_nettype wire

// ==== verilog/aca_host.sv ====
// Host end: turns register read and write requests into command frames.
// Assumes the device end on the same clock answering reads in three bytes.
`include "aca_params.svh"
`default_nettype none

module aca_host
    import aca_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    aca_if.host link,
    input wire logic req_valid,
    input wire logic req_write,
    input wire aca_pkg::aca_byte_t req_addr,
    input wire aca_pkg::aca_byte_t req_wdata,
    output logic busy,
    output logic done,
    output logic rd_ok,
    output aca_pkg::aca_byte_t rd_data
);
    import aca_pkg::*;

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    aca_host_state_t state_ff;
    logic write_ff;
    aca_byte_t addr_ff;
    aca_byte_t wdata_ff;
    logic cmd_valid_ff;
    aca_byte_t cmd_byte_ff;
    logic done_ff;
    logic ok_ff;
    aca_byte_t data_ff;

    // Answer checks against the expected acknowledge and address.
    wire logic got = link.rsp_valid;
    wire logic ack_good = link.rsp_byte == `ACA_ACK_BYTE;
    wire logic adr_good = link.rsp_byte == addr_ff;
    wire logic start = (state_ff == HST_IDLE) && req_valid;

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------

    // sends FF 02 then escape and address, or address and value.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= HST_IDLE;
            write_ff <= 1'b0;
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            cmd_valid_ff <= 1'b0;
            cmd_byte_ff <= 8'h00;
        end else begin
            unique case (state_ff)
                HST_IDLE: begin
                    cmd_valid_ff <= start;
                    cmd_byte_ff <= start ? `ACA_HDR_BYTE : 8'h00;
                    if (start) begin
                        write_ff <= req_write;
                        addr_ff <= req_addr;
                        wdata_ff <= req_wdata;
                        state_ff <= HST_SIZE;
                    end
                end
                HST_SIZE: begin
                    cmd_byte_ff <= `ACA_SIZE_BYTE;
                    state_ff <= HST_B3;
                end
                HST_B3: begin
                    cmd_byte_ff <= write_ff ? addr_ff : `ACA_ESC_BYTE;
                    state_ff <= HST_B4;
                end
                HST_B4: begin
                    cmd_byte_ff <= write_ff ? wdata_ff : addr_ff;
                    state_ff <= write_ff ? HST_IDLE : HST_WACK;
                end
                HST_WACK: begin
                    cmd_valid_ff <= 1'b0;
                    if (got) state_ff <= HST_WADR;
                end
                HST_WADR: begin
                    cmd_valid_ff <= 1'b0;
                    if (got) state_ff <= HST_WVAL;
                end
                HST_WVAL: begin
                    cmd_valid_ff <= 1'b0;
                    if (got) state_ff <= HST_IDLE;
                end
            endcase
        end
    end

    // collects the answer and reports whether it was well formed.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_ff <= 1'b0;
            ok_ff <= 1'b0;
            data_ff <= 8'h00;
        end else begin
            done_ff <= ((state_ff == HST_B4) && write_ff) || ((state_ff == HST_WVAL) && got);
            if (start) ok_ff <= 1'b1;
            if ((state_ff == HST_WACK) && got && !ack_good) ok_ff <= 1'b0;
            if ((state_ff == HST_WADR) && got && !adr_good) ok_ff <= 1'b0;
            if ((state_ff == HST_WVAL) && got) data_ff <= link.rsp_byte;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.cmd_valid = cmd_valid_ff;
    assign link.cmd_byte = cmd_byte_ff;
    assign busy = state_ff != HST_IDLE;
    assign done = done_ff;
    assign rd_ok = ok_ff;
    assign rd_data = data_ff;
endmodule

`default_nettype wire

// ==== verilog/aca_if.sv ====
// Byte link between the host controller and the device.
// Assumes both ends share one clock; one byte moves per valid cycle.
`default_nettype none

interface aca_if;
    logic cmd_valid;
    aca_pkg::aca_byte_t cmd_byte;
    logic rsp_valid;
    aca_pkg::aca_byte_t rsp_byte;

    modport dev (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_byte);
    modport host (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_byte);
endinterface

`default_nettype wire

// ==== verilog/aca_params.svh ====
// Constants for the addressing configuration register group.
// Assumes inclusion by bare name from the package and both ends.
`ifndef ACA_PARAMS_SVH
`define ACA_PARAMS_SVH

// ----------------------------------------------------------------
// Command frame bytes
// ----------------------------------------------------------------
`define ACA_HDR_BYTE 8'hFF
`define ACA_SIZE_BYTE 8'h02
`define ACA_ESC_BYTE 8'hFE
`define ACA_ACK_BYTE 8'h06

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACA_OFS_LINK_MODE_NV 8'h25
`define ACA_OFS_CAPTURE_NV 8'h26
`define ACA_OFS_SERIAL3 8'h34
`define ACA_OFS_SERIAL2 8'h35
`define ACA_OFS_SERIAL1 8'h36
`define ACA_OFS_SERIAL0 8'h37
`define ACA_OFS_CUST_HIGH 8'h39
`define ACA_OFS_CUST_LOW 8'h3A
`define ACA_OFS_LINK_MODE_V 8'h70
`define ACA_OFS_CAPTURE_V 8'h71

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define ACA_MODE_LEGACY 8'h00
`define ACA_MODE_NORMAL 8'h02
`define ACA_MODE_NETWORK 8'h03
`define ACA_CAP_OFF 4'h0
`define ACA_CAP_ANY 4'hF
`define ACA_TYPE_SERIAL 4'h4
`define ACA_TYPE_USER 4'h6
`define ACA_TYPE_EXT_USER 4'h7
`define ACA_RST_LINK_MODE 8'h02
`define ACA_RST_CAPTURE 4'h0
`define ACA_RST_SERIAL 32'h1234_5678
`define ACA_RST_CUSTOMER 16'hA5C3

`endif

// ==== verilog/aca_pkg.sv ====
// Types shared by both ends of the addressing configuration link.
// Assumes the constants header sits beside this file.
`include "aca_params.svh"
`default_nettype none

package aca_pkg;
    // Device command parser and answer sequencer states.
    typedef enum logic [2:0] {
        DEV_HDR = 3'h0,
        DEV_SIZE = 3'h1,
        DEV_FIRST = 3'h3,
        DEV_RADDR = 3'h2,
        DEV_ACK = 3'h6,
        DEV_RSPA = 3'h7,
        DEV_RVAL = 3'h5,
        DEV_WVAL = 3'h4
    } aca_dev_state_t;

    // Host command sender states.
    typedef enum logic [2:0] {
        HST_IDLE = 3'h0,
        HST_SIZE = 3'h1,
        HST_B3 = 3'h3,
        HST_B4 = 3'h2,
        HST_WACK = 3'h6,
        HST_WADR = 3'h7,
        HST_WVAL = 3'h5
    } aca_host_state_t;

    typedef logic [7:0] aca_byte_t;
    typedef logic [3:0] aca_nibble_t;
endpackage

`default_nettype wire
